// File: r3e_pkg.sv
// Package: register map, field layout and timing for the rail 3 enable gating block
package r3e_pkg;
    localparam logic [7:0] ADDR_GOOD_MASK_PRIMARY = 8'h0A;
    localparam logic [7:0] ADDR_GOOD_MASK_AND_SOURCE = 8'h0E;
    localparam logic [7:0] ADDR_EDGE_DELAYS = 8'h0F;
    localparam logic [7:0] RESET_GOOD_MASK_PRIMARY = 8'h00;
    localparam logic [7:0] RESET_GOOD_MASK_AND_SOURCE = 8'h00;
    localparam logic [7:0] RESET_EDGE_DELAYS = 8'h00;
    localparam int SRC_SEL_MSB = 4;
    localparam int SRC_SEL_LSB = 2;
    localparam int MASK_SWITCH_B2_LINEAR_A1_BIT = 1;
    localparam int MASK_SWITCH_B1_BIT = 0;
    localparam int FALL_DLY_MSB = 5;
    localparam int FALL_DLY_LSB = 3;
    localparam int RISE_DLY_MSB = 2;
    localparam int RISE_DLY_LSB = 0;
    localparam int NUM_GOOD = 10;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int TICK_TIME_MS = 2;
    localparam int TICK_CYCLES = TICK_TIME_MS * MS_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 21;
    localparam int DLY_W = 6;

    typedef enum logic [2:0] {
        SRC_PIN1, SRC_PIN2, SRC_PIN5, SRC_PIN4, SRC_PIN3, SRC_PIN34, SRC_PIN6, SRC_ONE
    } r3e_src_t;

    // Delay in 2 ms ticks: 0, 2, 4, 8, 16, 24, 32, 64 ms
    function automatic logic [DLY_W-1:0] r3e_ticks(input logic [2:0] code);
        unique case (code)
            3'h0: r3e_ticks = 6'h00;
            3'h1: r3e_ticks = 6'h01;
            3'h2: r3e_ticks = 6'h02;
            3'h3: r3e_ticks = 6'h04;
            3'h4: r3e_ticks = 6'h08;
            3'h5: r3e_ticks = 6'h0C;
            3'h6: r3e_ticks = 6'h10;
            3'h7: r3e_ticks = 6'h20;
        endcase
    endfunction
endpackage

// File: r3e_enable_gating.sv
// Rail 3 enable source select, edge delay and power-good gating
`timescale 1ns/1ns
`default_nettype none
module r3e_enable_gating
    import r3e_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [5:0] control_pin,
    input wire logic power_good_stepdown1,
    input wire logic power_good_stepdown2,
    input wire logic power_good_stepdown4,
    input wire logic power_good_stepdown5,
    input wire logic power_good_stepdown6,
    input wire logic power_good_switch_a1,
    input wire logic power_good_linear_a2,
    input wire logic power_good_linear_a3,
    input wire logic power_good_switch_b1,
    input wire logic power_good_switch_b2_linear_a1,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic rail3_delayed_source,
    output logic rail3_enable
);
    import r3e_pkg::*;

    typedef struct packed {
        logic [7:0] mask_primary_r;
        logic [7:0] mask_source_r;
        logic [7:0] delays_r;
        logic [TICK_W-1:0] tick_cnt_r;
        logic [DLY_W-1:0] dly_cnt_r;
        logic src_delayed_r;
        logic enable_r;
        logic [7:0] rdata_r;
    } r3e_state_t;

    r3e_state_t st_r;
    r3e_state_t st_nxt;
    logic src_raw;
    logic goods_ok;
    logic [NUM_GOOD-1:0] good_vec;
    logic [NUM_GOOD-1:0] mask_vec;
    logic [DLY_W-1:0] target;
    r3e_src_t sel;

    always_comb
    begin
        sel = r3e_src_t'(st_r.mask_source_r[SRC_SEL_MSB:SRC_SEL_LSB]);
        unique case (sel)
            SRC_PIN1: src_raw = control_pin[0];
            SRC_PIN2: src_raw = control_pin[1];
            SRC_PIN5: src_raw = control_pin[4];
            SRC_PIN4: src_raw = control_pin[3];
            SRC_PIN3: src_raw = control_pin[2];
            SRC_PIN34: src_raw = control_pin[2] & control_pin[3];
            SRC_PIN6: src_raw = control_pin[5];
            SRC_ONE: src_raw = 1'b1;
        endcase
    end

    // Bit order of the primary mask register, then the two secondary masks
    assign good_vec = {power_good_switch_b2_linear_a1, power_good_switch_b1,
                       power_good_linear_a3, power_good_linear_a2, power_good_switch_a1,
                       power_good_stepdown6, power_good_stepdown5, power_good_stepdown4,
                       power_good_stepdown2, power_good_stepdown1};
    assign mask_vec = {st_r.mask_source_r[MASK_SWITCH_B2_LINEAR_A1_BIT],
                       st_r.mask_source_r[MASK_SWITCH_B1_BIT],
                       st_r.mask_primary_r};
    assign goods_ok = &(good_vec | mask_vec);

    always_comb
    begin
        st_nxt = st_r;
        target = src_raw ? r3e_ticks(st_r.delays_r[RISE_DLY_MSB:RISE_DLY_LSB])
                         : r3e_ticks(st_r.delays_r[FALL_DLY_MSB:FALL_DLY_LSB]);
        if (reg_write)
        begin
            if (reg_addr == ADDR_GOOD_MASK_PRIMARY)
                st_nxt.mask_primary_r = reg_wdata;
            if (reg_addr == ADDR_GOOD_MASK_AND_SOURCE)
                st_nxt.mask_source_r = reg_wdata;
            if (reg_addr == ADDR_EDGE_DELAYS)
                st_nxt.delays_r = reg_wdata;
        end
        unique case (reg_addr)
            ADDR_GOOD_MASK_PRIMARY: st_nxt.rdata_r = st_r.mask_primary_r;
            ADDR_GOOD_MASK_AND_SOURCE: st_nxt.rdata_r = st_r.mask_source_r;
            ADDR_EDGE_DELAYS: st_nxt.rdata_r = st_r.delays_r;
            default: st_nxt.rdata_r = 8'h00;
        endcase
        // Glitch shorter than the delay restarts the wait: edge is filtered, not queued
        if (src_raw == st_r.src_delayed_r)
        begin
            st_nxt.tick_cnt_r = '0;
            st_nxt.dly_cnt_r = '0;
        end
        else if (st_r.dly_cnt_r >= target)
        begin
            st_nxt.src_delayed_r = src_raw;
            st_nxt.tick_cnt_r = '0;
            st_nxt.dly_cnt_r = '0;
        end
        else if (st_r.tick_cnt_r == TICK_W'(TICK_CYCLES_P - 1))
        begin
            // Exact tick from the system clock, well inside the allowed spread
            st_nxt.tick_cnt_r = '0;
            st_nxt.dly_cnt_r = st_r.dly_cnt_r + 6'h01;
        end
        else
            st_nxt.tick_cnt_r = st_r.tick_cnt_r + 21'h000001;
        st_nxt.enable_r = st_nxt.src_delayed_r & goods_ok;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            st_r <= '0;
            st_r.mask_primary_r <= RESET_GOOD_MASK_PRIMARY;
            st_r.mask_source_r <= RESET_GOOD_MASK_AND_SOURCE;
            st_r.delays_r <= RESET_EDGE_DELAYS;
        end
        else
            st_r <= st_nxt;
    end

    assign reg_rdata = st_r.rdata_r;
    assign rail3_delayed_source = st_r.src_delayed_r;
    assign rail3_enable = st_r.enable_r;

    enable_needs_source_a: assert property (@(posedge clk_sys) disable iff (reset)
        rail3_enable |-> rail3_delayed_source)
        else $error("enable high without delayed source");
    source_fall_drops_a: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(rail3_delayed_source) |-> !rail3_enable)
        else $error("enable still high after source fell");
    masked_good_a: assert property (@(posedge clk_sys) disable iff (reset)
        (st_r.src_delayed_r && !power_good_stepdown1 && !st_r.mask_primary_r[0]
         && !reg_write) |=> !rail3_enable)
        else $error("unmasked low good did not block enable");
    good_order_a: assert property (@(posedge clk_sys) disable iff (reset)
        (!power_good_linear_a3 && !st_r.mask_primary_r[7] && !reg_write) |=> !rail3_enable)
        else $error("bit 7 does not guard linear a3 good");
    secondary_mask_a: assert property (@(posedge clk_sys) disable iff (reset)
        (!power_good_switch_b1 && !st_r.mask_source_r[0] && !reg_write) |=> !rail3_enable)
        else $error("bit 0 does not guard switch b1 good");
    const_source_a: assert property (@(posedge clk_sys) disable iff (reset)
        (sel == SRC_ONE) |-> src_raw)
        else $error("constant source not high");
    no_delay_rise_a: assert property (@(posedge clk_sys) disable iff (reset)
        (src_raw && !rail3_delayed_source && st_r.delays_r[2:0] == 3'h0 && !reg_write)
        |=> rail3_delayed_source)
        else $error("zero rise delay not immediate");
    delay_held_a: assert property (@(posedge clk_sys) disable iff (reset)
        (st_r.dly_cnt_r != '0 && st_r.dly_cnt_r < target) |=> $stable(rail3_delayed_source))
        else $error("delayed source moved before its delay");

    // Whole-path checks for SRC_ONE and SRC_PIN34, so a wrong decode cannot hide behind its own expression
    const_source_rise_a: assert property (@(posedge clk_sys) disable iff (reset)
        (sel == SRC_ONE && st_r.delays_r[RISE_DLY_MSB:RISE_DLY_LSB] == 3'h0 && !reg_write)
        |=> rail3_delayed_source)
        else $error("constant source did not raise delayed source");

    pair_needs_both_a: assert property (@(posedge clk_sys) disable iff (reset)
        (sel == SRC_PIN34 && !(control_pin[2] && control_pin[3]) && !reg_write
         && st_r.delays_r[FALL_DLY_MSB:FALL_DLY_LSB] == 3'h0) |=> !rail3_delayed_source)
        else $error("paired source high with one pin low");

    no_delay_fall_a: assert property (@(posedge clk_sys) disable iff (reset)
        (!src_raw && rail3_delayed_source
         && st_r.delays_r[FALL_DLY_MSB:FALL_DLY_LSB] == 3'h0) |=> !rail3_delayed_source)
        else $error("zero fall delay not immediate");

    early_edge_a: assert property (@(posedge clk_sys) disable iff (reset)
        (st_r.dly_cnt_r < target) |=> $stable(rail3_delayed_source))
        else $error("delayed source moved before its count");

    tick_bound_a: assert property (@(posedge clk_sys) disable iff (reset)
        st_r.tick_cnt_r <= TICK_W'(TICK_CYCLES_P - 1))
        else $error("tick counter ran past its period");

    enable_follows_a: assert property (@(posedge clk_sys) disable iff (reset)
        (rail3_delayed_source && src_raw && goods_ok) |=> rail3_enable)
        else $error("enable low with source and goods ready");

    good_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
        !goods_ok |=> !rail3_enable)
        else $error("enable high with an unmasked good low");

    all_masked_a: assert property (@(posedge clk_sys) disable iff (reset)
        (&mask_vec && rail3_delayed_source && src_raw) |=> rail3_enable)
        else $error("fully masked goods still blocked enable");

    primary_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_write && reg_addr == ADDR_GOOD_MASK_PRIMARY)
        |=> st_r.mask_primary_r == $past(reg_wdata))
        else $error("primary mask write lost");

    source_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_write && reg_addr == ADDR_GOOD_MASK_AND_SOURCE)
        |=> st_r.mask_source_r == $past(reg_wdata))
        else $error("mask and source write lost");

    delays_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_write && reg_addr == ADDR_EDGE_DELAYS)
        |=> st_r.delays_r == $past(reg_wdata))
        else $error("edge delay write lost");

    read_back_a: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_addr == ADDR_EDGE_DELAYS) |=> reg_rdata == $past(st_r.delays_r))
        else $error("delay register read back wrong");
endmodule // r3e_enable_gating
`default_nettype wire

// File: r3e_host_model.sv
// Host-side model: drives control pins and power-good levels
`timescale 1ns/1ns
`default_nettype none
module r3e_host_model
(
    input wire logic clk_sys,
    input wire logic [5:0] pin_req,
    input wire logic [9:0] good_req,
    output logic [5:0] control_pin,
    output logic [9:0] power_good
);
    // Levels move only off the sampling edge
    always_ff @(negedge clk_sys)
    begin
        control_pin <= pin_req;
        power_good <= good_req;
    end
endmodule // r3e_host_model
`default_nettype wire

// File: r3e_enable_gating_tb.sv
// Testbench for the rail 3 enable gating block
`timescale 1ns/1ns
`default_nettype none
module r3e_enable_gating_tb;
    import r3e_pkg::*;
    logic clk_sys = 0, reset = 1, reg_write = 0, dsrc, en;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [5:0] pin_req = 0, control_pin;
    logic [9:0] good_req = 0, pg;
    int err_count = 0, n_tests = 0, n;
    int tk[8] = '{0, 1, 2, 4, 8, 12, 16, 32};
    logic [5:0] sm[8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0C, 6'h20, 6'h00};
    always #5 clk_sys = ~clk_sys;
    r3e_host_model r3e_host_model_i (.clk_sys(clk_sys), .pin_req(pin_req), .good_req(good_req),
        .control_pin(control_pin), .power_good(pg));
    // Short tick keeps the 64 ms case to a few hundred cycles
    r3e_enable_gating #(.TICK_CYCLES_P(10)) r3e_enable_gating_i (.clk_sys(clk_sys),
        .reset(reset), .control_pin(control_pin), .power_good_stepdown1(pg[0]),
        .power_good_stepdown2(pg[1]), .power_good_stepdown4(pg[2]), .power_good_stepdown5(pg[3]),
        .power_good_stepdown6(pg[4]), .power_good_switch_a1(pg[5]), .power_good_linear_a2(pg[6]),
        .power_good_linear_a3(pg[7]), .power_good_switch_b1(pg[8]),
        .power_good_switch_b2_linear_a1(pg[9]), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rail3_delayed_source(dsrc),
        .rail3_enable(en));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_write = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_write = 0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        reg_addr = a;
        @(negedge clk_sys);
        chk(reg_rdata, exp);
    endtask
    // Bounded wait for the delayed source; 10 percent slack plus pipeline
    task automatic meas(input logic t, input int ticks);
        n = 0;
        while (dsrc !== t && n < 800)
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        if (n >= 800)
        begin
            err_count++;
            tally_and_finish();
        end
        chk(8'(n >= ticks * 9 && n <= ticks * 11 + 4), 8'h01);
    endtask
    initial
    begin
        repeat (5) @(negedge clk_sys);
        reset = 0;
        rdc(ADDR_GOOD_MASK_PRIMARY, 8'h00);
        rdc(ADDR_EDGE_DELAYS, 8'h00);
        wr(8'h20, 8'h55);
        rdc(8'h20, 8'h00);
        wr(ADDR_GOOD_MASK_AND_SOURCE, 8'hFF);
        rdc(ADDR_GOOD_MASK_AND_SOURCE, 8'hFF);
        wr(ADDR_GOOD_MASK_PRIMARY, 8'hFF);
        rdc(ADDR_GOOD_MASK_PRIMARY, 8'hFF);
        for (int c = 0; c < 8; c++)
        begin
            wr(ADDR_GOOD_MASK_AND_SOURCE, {3'h0, 3'(c), 2'h3});
            pin_req <= ~sm[c];
            repeat (4) @(negedge clk_sys);
            chk(dsrc, 8'(c == 7));
            chk(en, 8'(c == 7));
            // Pair select must need both pins, not either one
            if (c == 5)
            begin
                pin_req <= 6'h37;
                repeat (4) @(negedge clk_sys);
                chk(dsrc, 8'h00);
                pin_req <= 6'h3B;
                repeat (4) @(negedge clk_sys);
                chk(dsrc, 8'h00);
            end
            pin_req <= sm[c];
            repeat (4) @(negedge clk_sys);
            chk(en, 8'h01);
        end
        good_req <= 10'h3FF;
        wr(ADDR_GOOD_MASK_AND_SOURCE, 8'h1C);
        wr(ADDR_GOOD_MASK_PRIMARY, 8'h00);
        for (int g = 0; g < 10; g++)
        begin
            good_req <= 10'h3FF ^ (10'h001 << g);
            repeat (4) @(negedge clk_sys);
            chk(en, 8'h00);
            if (g < 8)
                wr(ADDR_GOOD_MASK_PRIMARY, 8'h01 << g);
            else
                wr(ADDR_GOOD_MASK_AND_SOURCE, 8'h1C | (8'h01 << (g - 8)));
            repeat (3) @(negedge clk_sys);
            chk(en, 8'h01);
            good_req <= 10'h3FF;
            wr(ADDR_GOOD_MASK_PRIMARY, 8'h00);
            wr(ADDR_GOOD_MASK_AND_SOURCE, 8'h1C);
        end
        wr(ADDR_GOOD_MASK_AND_SOURCE, 8'h03);
        pin_req <= 6'h00;
        // Rise and fall codes differ so swapped fields show
        for (int d = 0; d < 8; d++)
        begin
            wr(ADDR_EDGE_DELAYS, {2'h0, 3'(7 - d), 3'(d)});
            pin_req <= 6'h01;
            meas(1'b1, tk[d]);
            @(negedge clk_sys);
            pin_req <= 6'h00;
            meas(1'b0, tk[7 - d]);
        end
        // Mid-run reset must clear written fields and drop the enable
        wr(ADDR_EDGE_DELAYS, 8'h38);
        wr(ADDR_GOOD_MASK_AND_SOURCE, 8'h1C);
        repeat (3) @(negedge clk_sys);
        chk(en, 8'h01);
        reset = 1;
        repeat (2) @(negedge clk_sys);
        reset = 0;
        chk(en, 8'h00);
        chk(dsrc, 8'h00);
        rdc(ADDR_GOOD_MASK_AND_SOURCE, 8'h00);
        rdc(ADDR_EDGE_DELAYS, 8'h00);
        tally_and_finish();
    end
endmodule // r3e_enable_gating_tb
`default_nettype wire
